// ==== hdl/sdfwi_pkg.sv ====
// Constants, field positions and state codes of the serial control and status unit.
package sdfwi_pkg;

  // Register offsets.
  localparam logic [2:0] OFS_FIRST_CTRL  = 3'h0;
  localparam logic [2:0] OFS_SECOND_CTRL = 3'h1;
  localparam logic [2:0] OFS_IRQ_EN      = 3'h2;
  localparam logic [2:0] OFS_STATUS      = 3'h3;
  localparam logic [2:0] OFS_DATA_PORT   = 3'h4;
  localparam logic [2:0] OFS_POLY        = 3'h5;
  localparam logic [2:0] OFS_RX_CHECK    = 3'h6;
  localparam logic [2:0] OFS_TX_CHECK    = 3'h7;

  // First control register fields.
  localparam int B_LSB_FIRST  = 7;
  localparam int B_PERIPH_EN  = 6;
  localparam int B_BAUD_HI    = 5;
  localparam int B_BAUD_LO    = 3;
  localparam int B_MASTER_SEL = 2;
  localparam int B_CLK_POL    = 1;
  localparam int B_CLK_PHASE  = 0;

  // Second control register fields.
  localparam int B_ONE_LINE     = 7;
  localparam int B_ONE_LINE_OUT = 6;
  localparam int B_CHECK_EN     = 5;
  localparam int B_CHECK_NEXT   = 4;
  localparam int B_RECV_ONLY    = 2;
  localparam int B_SOFT_SEL     = 1;
  localparam int B_INT_SEL      = 0;

  // Interrupt enable register fields; the low nibble is reserved.
  localparam int B_TXE_IE  = 7;
  localparam int B_RXF_IE  = 6;
  localparam int B_ERR_IE  = 5;
  localparam int B_WAKE_IE = 4;
  localparam logic [7:0] IRQ_EN_MASK = 8'hf0;

  // Status register fields.
  localparam int B_BUSY     = 7;
  localparam int B_OVERRUN  = 6;
  localparam int B_FAULT    = 5;
  localparam int B_MISMATCH = 4;
  localparam int B_WAKE     = 3;
  localparam int B_TX_EMPTY = 1;
  localparam int B_RX_FULL  = 0;

  // Reset values.
  localparam logic [7:0] RST_CTRL   = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h02;
  localparam logic [7:0] RST_POLY   = 8'h07;
  localparam logic [7:0] RST_DATA   = 8'h00;

  // Index of the last bit of a byte.
  localparam logic [2:0] LAST_BIT = 3'h7;

  // Shift engine states, Gray coded along idle, first half, second half.
  typedef enum logic [1:0] {
    SDFWI_IDLE        = 2'b00,
    SDFWI_FIRST_HALF  = 2'b01,
    SDFWI_SECOND_HALF = 2'b11
  } sdfwi_state_t;

endpackage

// ==== hdl/sdfwi_top.sv ====
// Serial peripheral control, error flags, Halt wake-up and interrupt request logic.
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/10ps
module sdfwi_top (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       halt_mode,
  input  wire logic       sck_in,
  output logic            sck_out,
  output logic            sck_oe,
  input  wire logic       mosi_in,
  output logic            mosi_out,
  output logic            mosi_oe,
  input  wire logic       miso_in,
  output logic            miso_out,
  output logic            miso_oe,
  input  wire logic       select_in_pin,
  output logic            irq,
  output logic            wait_exit,
  output logic            halt_exit
);

  // Pin synchronisers: three stages, the filtered level follows once stages two and three agree.
  logic [3:0] pin_raw;
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic [3:0] pin_s3_q;
  logic [3:0] pin_f_d;
  logic [3:0] pin_f_q;
  assign pin_raw = {select_in_pin, miso_in, mosi_in, sck_in};

  // One synchroniser per pin.
  for (genvar i = 0; i < 4; i++) begin : g_sync
    always_comb begin
      pin_f_d[i] = (pin_s2_q[i] == pin_s3_q[i]) ? pin_s2_q[i] : pin_f_q[i];
    end
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        pin_s1_q[i] <= 1'b1;
        pin_s2_q[i] <= 1'b1;
        pin_s3_q[i] <= 1'b1;
        pin_f_q[i]  <= 1'b1;
      end else begin
        pin_s1_q[i] <= pin_raw[i];
        pin_s2_q[i] <= pin_s1_q[i];
        pin_s3_q[i] <= pin_s2_q[i];
        pin_f_q[i]  <= pin_f_d[i];
      end
    end
  end

  // Register and engine state.
  logic [7:0] cr1_q, cr1_d, cr2_q, cr2_d, icr_q, icr_d;
  logic [7:0] tx_buf_q, tx_buf_d, rx_buf_q, rx_buf_d, poly_q, poly_d;
  logic [7:0] rx_check_q, rx_check_d, tx_check_q, tx_check_d;
  logic [7:0] tx_sh_q, tx_sh_d, rx_sh_q, rx_sh_d, div_q, div_d, rdata_q, rdata_d;
  logic [2:0] bit_cnt_q, bit_cnt_d;
  logic       link_busy_flag_q, link_busy_flag_d, overrun_flag_q, overrun_flag_d;
  logic       master_fault_flag_q, master_fault_flag_d;
  logic       check_mismatch_flag_q, check_mismatch_flag_d, wake_flag_q, wake_flag_d;
  logic       tx_empty_flag_q, tx_empty_flag_d, rx_full_flag_q, rx_full_flag_d;
  logic       sending_check_q, sending_check_d, sck_q, sck_d, out_bit_q, out_bit_d;
  logic       ovr_arm_q, ovr_arm_d, fault_arm_q, fault_arm_d, sck_prev_q;
  sdfwi_pkg::sdfwi_state_t state_q, state_d;

  // Configuration views of the control registers.
  logic       periph_enable_bit, master_select_bit, clock_phase_sel, clk_pol, lsb_first;
  logic       one_line_mode_bit, one_line_drive_out_bit, receive_only_bit;
  logic       check_calc_enable, check_next, soft_select, internal_select_bit;
  logic [2:0] baud_sel;
  assign lsb_first              = cr1_q[sdfwi_pkg::B_LSB_FIRST];
  assign periph_enable_bit      = cr1_q[sdfwi_pkg::B_PERIPH_EN];
  assign baud_sel               = cr1_q[sdfwi_pkg::B_BAUD_HI:sdfwi_pkg::B_BAUD_LO];
  assign master_select_bit      = cr1_q[sdfwi_pkg::B_MASTER_SEL];
  assign clk_pol                = cr1_q[sdfwi_pkg::B_CLK_POL];
  assign clock_phase_sel        = cr1_q[sdfwi_pkg::B_CLK_PHASE];
  assign one_line_mode_bit      = cr2_q[sdfwi_pkg::B_ONE_LINE];
  assign one_line_drive_out_bit = cr2_q[sdfwi_pkg::B_ONE_LINE_OUT];
  assign check_calc_enable      = cr2_q[sdfwi_pkg::B_CHECK_EN];
  assign check_next             = cr2_q[sdfwi_pkg::B_CHECK_NEXT];
  assign receive_only_bit       = cr2_q[sdfwi_pkg::B_RECV_ONLY];
  assign soft_select            = cr2_q[sdfwi_pkg::B_SOFT_SEL];
  assign internal_select_bit    = cr2_q[sdfwi_pkg::B_INT_SEL];

  // Derived conditions of the link.
  logic       selected, rx_mode, out_allowed, master_rx_line, in_bit;
  logic       sck_edge, lead_edge, trail_edge, slave_sample_edge, slave_shift_edge;
  logic       master_go, stop_cond, fault_event;
  logic [7:0] half_m1, src_byte;
  assign selected       = soft_select ? ~internal_select_bit : ~pin_f_q[3];
  assign rx_mode        = one_line_mode_bit ? ~one_line_drive_out_bit : receive_only_bit;
  assign out_allowed    = one_line_mode_bit ? one_line_drive_out_bit : ~receive_only_bit;
  assign master_rx_line = master_select_bit & one_line_mode_bit & ~one_line_drive_out_bit;
  // In one-line mode the master listens on its own output line, the slave on its.
  assign in_bit = (master_select_bit ^ one_line_mode_bit) ? pin_f_q[2] : pin_f_q[1];
  assign sck_edge   = pin_f_q[0] ^ sck_prev_q;
  assign lead_edge  = sck_edge & (pin_f_q[0] != clk_pol);
  assign trail_edge = sck_edge & (pin_f_q[0] == clk_pol);
  assign slave_sample_edge = clock_phase_sel ? trail_edge : lead_edge;
  assign slave_shift_edge  = clock_phase_sel ? lead_edge : trail_edge;
  assign half_m1  = (8'h01 << baud_sel) - 8'h01;
  assign src_byte = (check_next & tx_empty_flag_q) ? tx_check_q : tx_buf_q;
  // A receiving master runs without data; otherwise it needs a byte or a pending check value.
  assign master_go = periph_enable_bit & (~tx_empty_flag_q | check_next | rx_mode);
  // Receive-only links finish the byte in flight before a disable takes hold.
  assign stop_cond = ~periph_enable_bit & ~rx_mode;
  assign fault_event = master_select_bit & selected;

  // Bit that leaves first, and the two shift directions.
  function automatic logic sdfwi_head(input logic [7:0] x, input logic lsb);
    return lsb ? x[0] : x[7];
  endfunction
  function automatic logic [7:0] sdfwi_shift(input logic [7:0] x, input logic b, input logic lsb);
    return lsb ? {b, x[7:1]} : {x[6:0], b};
  endfunction
  // One serial step of the check value with the programmed polynomial.
  function automatic logic [7:0] sdfwi_crc(input logic [7:0] c, input logic b, input logic [7:0] p);
    return {c[6:0], 1'b0} ^ (((c[7] ^ b) == 1'b1) ? p : 8'h00);
  endfunction

  // Register access, shift engine, flags; everything but the wake flag holds still while halted.
  logic       sample_now, shift_now, start_now, done_now;
  logic [7:0] rx_now;
  always_comb begin
    cr1_d = cr1_q;
    cr2_d = cr2_q;
    icr_d = icr_q;
    tx_buf_d = tx_buf_q;
    rx_buf_d = rx_buf_q;
    poly_d = poly_q;
    rx_check_d = rx_check_q;
    tx_check_d = tx_check_q;
    tx_sh_d = tx_sh_q;
    rx_sh_d = rx_sh_q;
    div_d = div_q;
    bit_cnt_d = bit_cnt_q;
    link_busy_flag_d = link_busy_flag_q;
    overrun_flag_d = overrun_flag_q;
    master_fault_flag_d = master_fault_flag_q;
    check_mismatch_flag_d = check_mismatch_flag_q;
    wake_flag_d = wake_flag_q;
    tx_empty_flag_d = tx_empty_flag_q;
    rx_full_flag_d = rx_full_flag_q;
    sending_check_d = sending_check_q;
    sck_d = sck_q;
    out_bit_d = out_bit_q;
    ovr_arm_d = ovr_arm_q;
    fault_arm_d = fault_arm_q;
    state_d = state_q;
    rdata_d = 8'h00;
    sample_now = 1'b0;
    shift_now = 1'b0;
    start_now = 1'b0;
    done_now = 1'b0;
    rx_now = sdfwi_shift(rx_sh_q, in_bit, lsb_first);
    if (!halt_mode) begin
      // Reads: clears of the data port and status sequences come first so that events win.
      if (reg_rd) begin
        unique case (reg_addr)
          sdfwi_pkg::OFS_FIRST_CTRL:  rdata_d = cr1_q;
          sdfwi_pkg::OFS_SECOND_CTRL: rdata_d = cr2_q;
          sdfwi_pkg::OFS_IRQ_EN:      rdata_d = icr_q;
          sdfwi_pkg::OFS_STATUS: begin
            rdata_d = {link_busy_flag_q, overrun_flag_q, master_fault_flag_q,
                       check_mismatch_flag_q, wake_flag_q, 1'b0, tx_empty_flag_q, rx_full_flag_q};
            if (ovr_arm_q) begin
              overrun_flag_d = 1'b0;
              ovr_arm_d = 1'b0;
            end
            fault_arm_d = master_fault_flag_q | fault_arm_q;
          end
          sdfwi_pkg::OFS_DATA_PORT: begin
            rdata_d = rx_buf_q;
            rx_full_flag_d = 1'b0;
            ovr_arm_d = overrun_flag_q;
          end
          sdfwi_pkg::OFS_POLY:     rdata_d = poly_q;
          sdfwi_pkg::OFS_RX_CHECK: rdata_d = rx_check_q;
          sdfwi_pkg::OFS_TX_CHECK: rdata_d = tx_check_q;
        endcase
      end
      if (reg_wr) begin
        unique case (reg_addr)
          sdfwi_pkg::OFS_FIRST_CTRL: begin
            cr1_d = reg_wdata;
            // A write may not raise enable or master select while a fault stands.
            cr1_d[sdfwi_pkg::B_PERIPH_EN]  = reg_wdata[sdfwi_pkg::B_PERIPH_EN] & ~master_fault_flag_q;
            cr1_d[sdfwi_pkg::B_MASTER_SEL] = reg_wdata[sdfwi_pkg::B_MASTER_SEL] & ~master_fault_flag_q;
            if (fault_arm_q) begin
              master_fault_flag_d = 1'b0;
              fault_arm_d = 1'b0;
            end
          end
          sdfwi_pkg::OFS_SECOND_CTRL: begin
            cr2_d = reg_wdata;
            if (reg_wdata[sdfwi_pkg::B_CHECK_EN]) begin
              rx_check_d = 8'h00;
              tx_check_d = 8'h00;
            end
          end
          sdfwi_pkg::OFS_IRQ_EN: icr_d = reg_wdata & sdfwi_pkg::IRQ_EN_MASK;
          sdfwi_pkg::OFS_STATUS: begin
            check_mismatch_flag_d = check_mismatch_flag_q & reg_wdata[sdfwi_pkg::B_MISMATCH];
            wake_flag_d = wake_flag_q & reg_wdata[sdfwi_pkg::B_WAKE];
            fault_arm_d = master_fault_flag_q | fault_arm_q;
          end
          sdfwi_pkg::OFS_DATA_PORT: begin
            tx_buf_d = reg_wdata;
            tx_empty_flag_d = 1'b0;
          end
          sdfwi_pkg::OFS_POLY: poly_d = reg_wdata;
          default: ;
        endcase
      end
      // Timing of the link: the master divides the clock, the slave follows sck edges.
      if (master_select_bit) begin
        unique case (state_q)
          sdfwi_pkg::SDFWI_IDLE: begin
            tx_sh_d = src_byte;
            out_bit_d = sdfwi_head(src_byte, lsb_first);
            sck_d = clk_pol;
            start_now = master_go;
          end
          sdfwi_pkg::SDFWI_FIRST_HALF: begin
            if (div_q == half_m1) begin
              div_d = 8'h00;
              sck_d = ~sck_q;
              state_d = sdfwi_pkg::SDFWI_SECOND_HALF;
              sample_now = ~clock_phase_sel;
              shift_now = clock_phase_sel;
            end else begin
              div_d = div_q + 8'h01;
            end
          end
          sdfwi_pkg::SDFWI_SECOND_HALF: begin
            if (div_q == half_m1) begin
              div_d = 8'h00;
              sck_d = ~sck_q;
              sample_now = clock_phase_sel;
              shift_now = ~clock_phase_sel;
              if (bit_cnt_q == sdfwi_pkg::LAST_BIT) begin
                done_now = 1'b1;
              end else begin
                bit_cnt_d = bit_cnt_q + 3'h1;
                state_d = sdfwi_pkg::SDFWI_FIRST_HALF;
              end
            end else begin
              div_d = div_q + 8'h01;
            end
          end
          // The unused code falls back to idle rather than locking up.
          default: state_d = sdfwi_pkg::SDFWI_IDLE;
        endcase
      end else begin
        if (state_q == sdfwi_pkg::SDFWI_IDLE) begin
          // The next byte, or the marker left in the buffer, stands ready on the line.
          tx_sh_d = src_byte;
          out_bit_d = sdfwi_head(src_byte, lsb_first);
          // Only a leading edge opens a byte, so the last trailing edge cannot start another.
          start_now = periph_enable_bit & selected & lead_edge;
        end
        if (state_q != sdfwi_pkg::SDFWI_IDLE || start_now) begin
          sample_now = slave_sample_edge;
          shift_now = slave_shift_edge;
          if (slave_sample_edge) begin
            if (bit_cnt_q == sdfwi_pkg::LAST_BIT) begin
              done_now = 1'b1;
            end else begin
              bit_cnt_d = bit_cnt_q + 3'h1;
            end
          end
        end
      end
      if (!sample_now) begin
        rx_now = rx_sh_q;
      end
      if (shift_now) begin
        out_bit_d = sdfwi_head(tx_sh_q, lsb_first);
      end
      // Sampling edge: both shifters move, the check values follow except during their own byte.
      if (sample_now) begin
        tx_sh_d = sdfwi_shift(tx_sh_q, 1'b0, lsb_first);
        rx_sh_d = rx_now;
        if (check_calc_enable && !sending_check_q) begin
          tx_check_d = sdfwi_crc(tx_check_q, sdfwi_head(tx_sh_q, lsb_first), poly_q);
          rx_check_d = sdfwi_crc(rx_check_q, in_bit, poly_q);
        end
      end
      if (done_now) begin
        if (sending_check_q && check_calc_enable && rx_now != rx_check_q) begin
          check_mismatch_flag_d = 1'b1;
        end
        // A full buffer or a standing overrun keeps the earlier byte and drops this one.
        if (rx_full_flag_q || overrun_flag_q) begin
          overrun_flag_d = overrun_flag_q | rx_full_flag_q;
        end else begin
          rx_buf_d = rx_now;
          rx_full_flag_d = 1'b1;
        end
        state_d = sdfwi_pkg::SDFWI_IDLE;
        link_busy_flag_d = 1'b0;
        bit_cnt_d = 3'h0;
        sending_check_d = 1'b0;
        // A master with more to do restarts at once, so busy never drops between bytes.
        start_now = master_select_bit & master_go;
      end
      if (start_now) begin
        // The bit count is left alone: a slave may already count its first sample here.
        state_d = sdfwi_pkg::SDFWI_FIRST_HALF;
        div_d = 8'h00;
        link_busy_flag_d = ~master_rx_line;
        if (master_select_bit) begin
          tx_sh_d = src_byte;
          out_bit_d = sdfwi_head(src_byte, lsb_first);
        end
        if (check_next && tx_empty_flag_q) begin
          sending_check_d = 1'b1;
          cr2_d[sdfwi_pkg::B_CHECK_NEXT] = 1'b0;
        end else begin
          tx_empty_flag_d = 1'b1;
        end
      end
      // Disable outside receive mode, or a slave losing its select, ends the transfer where it stands.
      if (state_q != sdfwi_pkg::SDFWI_IDLE && (stop_cond || (!master_select_bit && !selected))) begin
        state_d = sdfwi_pkg::SDFWI_IDLE;
        link_busy_flag_d = 1'b0;
        bit_cnt_d = 3'h0;
        sending_check_d = 1'b0;
        sck_d = clk_pol;
      end
      if (fault_event) begin
        master_fault_flag_d = 1'b1;
        cr1_d[sdfwi_pkg::B_PERIPH_EN] = 1'b0;
        cr1_d[sdfwi_pkg::B_MASTER_SEL] = 1'b0;
        link_busy_flag_d = 1'b0;
        state_d = sdfwi_pkg::SDFWI_IDLE;
        bit_cnt_d = 3'h0;
        sck_d = clk_pol;
      end
    end else if (periph_enable_bit && !master_select_bit && selected && slave_sample_edge) begin
      // Receive-only links may lose bytes here while the system clock restarts.
      wake_flag_d = 1'b1;
    end
  end

  // Registers of the engine and the register file.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cr1_q <= sdfwi_pkg::RST_CTRL;
      cr2_q <= sdfwi_pkg::RST_CTRL;
      icr_q <= sdfwi_pkg::RST_CTRL;
      tx_buf_q <= sdfwi_pkg::RST_DATA;
      rx_buf_q <= sdfwi_pkg::RST_DATA;
      poly_q <= sdfwi_pkg::RST_POLY;
      rx_check_q <= sdfwi_pkg::RST_DATA;
      tx_check_q <= sdfwi_pkg::RST_DATA;
      tx_sh_q <= sdfwi_pkg::RST_DATA;
      rx_sh_q <= sdfwi_pkg::RST_DATA;
      div_q <= 8'h00;
      rdata_q <= 8'h00;
      bit_cnt_q <= 3'h0;
      link_busy_flag_q <= sdfwi_pkg::RST_STATUS[sdfwi_pkg::B_BUSY];
      overrun_flag_q <= sdfwi_pkg::RST_STATUS[sdfwi_pkg::B_OVERRUN];
      master_fault_flag_q <= sdfwi_pkg::RST_STATUS[sdfwi_pkg::B_FAULT];
      check_mismatch_flag_q <= sdfwi_pkg::RST_STATUS[sdfwi_pkg::B_MISMATCH];
      wake_flag_q <= sdfwi_pkg::RST_STATUS[sdfwi_pkg::B_WAKE];
      tx_empty_flag_q <= sdfwi_pkg::RST_STATUS[sdfwi_pkg::B_TX_EMPTY];
      rx_full_flag_q <= sdfwi_pkg::RST_STATUS[sdfwi_pkg::B_RX_FULL];
      sending_check_q <= 1'b0;
      sck_q <= 1'b0;
      out_bit_q <= 1'b0;
      ovr_arm_q <= 1'b0;
      fault_arm_q <= 1'b0;
      sck_prev_q <= 1'b1;
      state_q <= sdfwi_pkg::SDFWI_IDLE;
    end else begin
      cr1_q <= cr1_d;
      cr2_q <= cr2_d;
      icr_q <= icr_d;
      tx_buf_q <= tx_buf_d;
      rx_buf_q <= rx_buf_d;
      poly_q <= poly_d;
      rx_check_q <= rx_check_d;
      tx_check_q <= tx_check_d;
      tx_sh_q <= tx_sh_d;
      rx_sh_q <= rx_sh_d;
      div_q <= div_d;
      rdata_q <= rdata_d;
      bit_cnt_q <= bit_cnt_d;
      link_busy_flag_q <= link_busy_flag_d;
      overrun_flag_q <= overrun_flag_d;
      master_fault_flag_q <= master_fault_flag_d;
      check_mismatch_flag_q <= check_mismatch_flag_d;
      wake_flag_q <= wake_flag_d;
      tx_empty_flag_q <= tx_empty_flag_d;
      rx_full_flag_q <= rx_full_flag_d;
      sending_check_q <= sending_check_d;
      sck_q <= sck_d;
      out_bit_q <= out_bit_d;
      ovr_arm_q <= ovr_arm_d;
      fault_arm_q <= fault_arm_d;
      sck_prev_q <= pin_f_q[0];
      state_q <= state_d;
    end
  end

  // Pin drivers and requests; all registered so the outputs come from flip-flops.
  logic sck_oe_d, mosi_oe_d, miso_oe_d, irq_d, wait_exit_d, halt_exit_d;
  logic sck_oe_q, mosi_oe_q, miso_oe_q, irq_q, wait_exit_q, halt_exit_q;
  always_comb begin
    sck_oe_d  = periph_enable_bit & master_select_bit;
    mosi_oe_d = periph_enable_bit & master_select_bit & out_allowed;
    miso_oe_d = periph_enable_bit & ~master_select_bit & selected & out_allowed;
    irq_d = (tx_empty_flag_q & icr_q[sdfwi_pkg::B_TXE_IE])
          | (rx_full_flag_q & icr_q[sdfwi_pkg::B_RXF_IE])
          | (wake_flag_q & icr_q[sdfwi_pkg::B_WAKE_IE])
          | ((master_fault_flag_q | overrun_flag_q | check_mismatch_flag_q)
             & icr_q[sdfwi_pkg::B_ERR_IE]);
    wait_exit_d = irq_d;
    halt_exit_d = wake_flag_q & icr_q[sdfwi_pkg::B_WAKE_IE];
  end

  // Output flops.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_oe_q <= 1'b0;
      mosi_oe_q <= 1'b0;
      miso_oe_q <= 1'b0;
      irq_q <= 1'b0;
      wait_exit_q <= 1'b0;
      halt_exit_q <= 1'b0;
    end else begin
      sck_oe_q <= sck_oe_d;
      mosi_oe_q <= mosi_oe_d;
      miso_oe_q <= miso_oe_d;
      irq_q <= irq_d;
      wait_exit_q <= wait_exit_d;
      halt_exit_q <= halt_exit_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign sck_out   = sck_q;
  assign sck_oe    = sck_oe_q;
  assign mosi_out  = out_bit_q;
  assign mosi_oe   = mosi_oe_q;
  assign miso_out  = out_bit_q;
  assign miso_oe   = miso_oe_q;
  assign irq       = irq_q;
  assign wait_exit = wait_exit_q;
  assign halt_exit = halt_exit_q;

endmodule

// ==== bench/sdfwi_sva.sv ====
// Port assertions for the serial control unit.
`timescale 1ns/10ps
module sdfwi_sva (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       halt_mode,
  input wire logic       sck_out,
  input wire logic       sck_oe,
  input wire logic       mosi_oe,
  input wire logic       miso_oe,
  input wire logic       select_in_pin,
  input wire logic       irq,
  input wire logic       wait_exit,
  input wire logic       halt_exit
);
  // All checks share one clock and the one reset.
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside slot");
  a_halt_reads: assert property ($past(reg_rd & halt_mode) |-> reg_rdata == 8'h00)
    else $error("read taken in halt");
  a_halt_frozen: assert property (halt_mode [*2] |-> $stable(sck_out))
    else $error("clock moved in halt");
  a_wait_mirror: assert property (wait_exit == irq)
    else $error("wait exit differs");
  a_halt_wake: assert property (halt_exit |-> irq)
    else $error("halt exit without request");
  a_fault_stop: assert property (sck_oe && $fell(select_in_pin) |-> ##[1:8] !sck_oe)
    else $error("master kept driving");
  a_off_quiet: assert property (!sck_oe |-> !mosi_oe)
    else $error("data driven while off");
  a_one_role: assert property (sck_oe |-> !miso_oe)
    else $error("both roles driven");
endmodule
bind sdfwi_top sdfwi_sva sdfwi_sva_inst (.*);

// ==== bench/sdfwi_peer.sv ====
// External link master: selects the unit and clocks one byte at a time.
`timescale 1ns/10ps
module sdfwi_peer (
  input wire logic clk,
  output logic     sck,
  output logic     mosi,
  output logic     sel_n,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    mosi = 1'b1;
    sel_n = 1'b1;
  end
  // Mode 0, msb first, eight clocks a bit; the clock stands still between frames.
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    sel_n <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      mosi <= tx[i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      rx[i] = miso;
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    sel_n <= 1'b1;
    mosi <= ~tx[0]; // Released line must not look like held data.
  endtask
endmodule

// ==== bench/sdfwi_top_tb.sv ====
// Self-checking bench for the serial control unit.
`timescale 1ns/10ps
module sdfwi_top_tb;
  logic       clk = 1'b0;
  logic       rstn, reg_wr, reg_rd, halt_mode, sel_tb;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, d, r, b0, b1;
  logic       sck, mosi, sel_n, miso, irq, halt_exit;
  int         failures = 0;
  int         samples_checked = 0;
  int         cyc = 0;
  always #20 clk = ~clk;
  sdfwi_top sdfwi_top_inst (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .halt_mode(halt_mode), .sck_in(sck), .sck_out(), .sck_oe(), .mosi_in(mosi),
    .mosi_out(), .mosi_oe(), .miso_in(1'b0), .miso_out(miso), .miso_oe(),
    .select_in_pin(sel_n & sel_tb), .irq(irq), .wait_exit(), .halt_exit(halt_exit));
  sdfwi_peer sdfwi_peer_inst (.clk(clk), .sck(sck), .mosi(mosi), .sel_n(sel_n), .miso(miso));
  task automatic summarize();
    if (failures == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Bus cycles: one-cycle strobes, read data taken in the following cycle.
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, v};
    @(posedge clk) reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] v);
    @(posedge clk) {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clk) reg_rd <= 1'b0;
    #1 v = reg_rdata;
  endtask
  // A hang ends the run as a failure.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      summarize();
    end
  end
  initial begin
    {reg_wr, reg_rd, halt_mode, reg_addr, reg_wdata} = '0;
    sel_tb = 1'b1;
    rstn = 1'b0;
    void'($urandom(99));
    b0 = 8'($urandom);
    b1 = 8'($urandom);
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    rd(3'h3, d); chk(d, 8'h02);
    wr(3'h2, 8'hff); rd(3'h2, d); chk(d, 8'hf0);
    chk({7'h0, irq}, 8'h01);
    wr(3'h2, 8'h20); rd(3'h2, d); chk({7'h0, irq}, 8'h00);
    wr(3'h0, 8'h44);
    @(posedge clk) sel_tb <= 1'b0;
    repeat (8) @(posedge clk);
    rd(3'h0, d); chk(d, 8'h00);
    wr(3'h0, 8'h44); rd(3'h0, d); chk(d, 8'h00);
    rd(3'h3, d); chk(d, 8'h22);
    chk({7'h0, irq}, 8'h01);
    wr(3'h0, 8'h00); repeat (6) @(posedge clk);
    rd(3'h3, d); chk(d, 8'h02);
    sel_tb <= 1'b1;
    wr(3'h1, 8'h04); wr(3'h0, 8'h40);
    sdfwi_peer_inst.xfer(b0, r);
    sdfwi_peer_inst.xfer(b1, r);
    repeat (8) @(posedge clk);
    rd(3'h3, d); chk(d, 8'h43);
    chk({7'h0, irq}, 8'h01);
    rd(3'h4, d); chk(d, b0);
    rd(3'h3, d); rd(3'h3, d); chk(d, 8'h02);
    wr(3'h1, 8'h00); wr(3'h4, b1); wr(3'h2, 8'h10);
    halt_mode <= 1'b1;
    sdfwi_peer_inst.xfer(b0, r);
    rd(3'h3, d); chk(d, 8'h00);
    chk({7'h0, halt_exit}, 8'h01);
    halt_mode <= 1'b0;
    rd(3'h3, d); chk(d & 8'h08, 8'h08);
    sdfwi_peer_inst.xfer(b0, r); chk(r, b1);
    rd(3'h3, d); chk(d & 8'h82, 8'h02);
    rd(3'h4, d); chk(d, b0);
    // Master receive-only, fast divider: take byte n-1, wait a serial clock, then disable.
    wr(3'h1, 8'h04); wr(3'h0, 8'h54);
    repeat (70) @(posedge clk);
    rd(3'h4, d); chk(d, 8'h00);
    rd(3'h3, d); chk(d, 8'h8a);
    repeat (8) @(posedge clk);
    wr(3'h0, 8'h14); repeat (60) @(posedge clk);
    rd(3'h3, d); chk(d, 8'h0b);
    rd(3'h4, d); chk(d, 8'h00);
    summarize();
  end
endmodule
